// ==== core/asd_consts.svh ====
// asd_consts.svh: opcode patterns, field positions and cycle counts for the decoder
// assumes: included by bare name; definitions only
`ifndef ASD_CONSTS_SVH
`define ASD_CONSTS_SVH
`define ASD_PFX_CS 8'h2e
`define ASD_PFX_SS 8'h36
`define ASD_PFX_DS 8'h3e
`define ASD_PFX_ES 8'h26
`define ASD_BCD_ADD 8'h37
`define ASD_PKD_ADD 8'h27
`define ASD_BCD_SUB 8'h3f
`define ASD_PKD_SUB 8'h2f
`define ASD_OP_ADD_RM 6'h00
`define ASD_OP_ADC_RM 6'h04
`define ASD_OP_SUB_RM 6'h0a
`define ASD_OP_SBB_RM 6'h06
`define ASD_OP_CMP_RM 6'h0e
`define ASD_OP_ADD_AC 7'h02
`define ASD_OP_ADC_AC 7'h0a
`define ASD_OP_SUB_AC 7'h16
`define ASD_OP_SBB_AC 7'h0e
`define ASD_OP_CMP_AC 7'h1e
`define ASD_OP_IMM_GRP 6'h20
`define ASD_OP_GRP3 7'h7b
`define ASD_OP_GRP4 7'h7f
`define ASD_OP_INC_R 5'h08
`define ASD_OP_DEC_R 5'h09
`define ASD_REG_ADD 3'h0
`define ASD_REG_ADC 3'h2
`define ASD_REG_SBB 3'h3
`define ASD_REG_SUB 3'h5
`define ASD_REG_CMP 3'h7
`define ASD_REG_NEG 3'h3
`define ASD_REG_MUL 3'h4
`define ASD_REG_INC 3'h0
`define ASD_REG_DEC 3'h1
`define ASD_MOD_REG 2'h3
`define ASD_CYC_PFX 7'h02
`define ASD_CYC_RR 7'h03
`define ASD_CYC_RM 7'h0a
`define ASD_CYC_IR 7'h04
`define ASD_CYC_IM 7'h10
`define ASD_CYC_AC8 7'h03
`define ASD_CYC_AC16 7'h04
`define ASD_CYC_CMPIM 7'h0a
`define ASD_CYC_INCM 7'h0f
`define ASD_CYC_BCD_ADD 7'h08
`define ASD_CYC_PKD 7'h04
`define ASD_CYC_BCD_SUB 7'h07
`define ASD_CYC_MUL_RB 7'h1a
`define ASD_CYC_MUL_RW 7'h23
`define ASD_CYC_MUL_MB 7'h20
`define ASD_CYC_MUL_MW 7'h29
`define ASD_CYC_MUL_SPAN 7'h02
`define ASD_CYC_NARROW 7'h04
`endif

// ==== core/asd_pkg.sv ====
// asd_pkg.sv: operation and segment types shared by the decoder modules
// assumes: compiled before any module that imports it
package asd_pkg;
    typedef enum logic [3:0] {
        ASD_OP_NONE = 4'h0, ASD_OP_ADD = 4'h1, ASD_OP_ADC = 4'h2, ASD_OP_SUB = 4'h3,
        ASD_OP_SBB = 4'h4, ASD_OP_CMP = 4'h5, ASD_OP_INC = 4'h6, ASD_OP_DEC = 4'h7,
        ASD_OP_NEG = 4'h8, ASD_OP_BCDA = 4'h9, ASD_OP_PKDA = 4'ha, ASD_OP_BCDS = 4'hb,
        ASD_OP_PKDS = 4'hc, ASD_OP_MUL = 4'hd
    } asd_op_t;
    typedef enum logic [2:0] {
        ASD_SEG_NONE = 3'h0, ASD_SEG_CS = 3'h1, ASD_SEG_SS = 3'h2,
        ASD_SEG_DS = 3'h3, ASD_SEG_ES = 3'h4
    } asd_seg_t;
    typedef enum logic [1:0] {
        ASD_ST_IDLE = 2'h0, ASD_ST_NEED_MODRM = 2'h1, ASD_ST_BUSY = 2'h2
    } asd_state_t;
endpackage : asd_pkg

// ==== core/asd_dec_if.sv ====
// asd_dec_if.sv: carrier from the pattern matcher to the sequencing logic
// assumes: both ends run on the same clock
`timescale 1ns/100ps
interface asd_dec_if;
    import asd_pkg::*;
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic known;
    logic needs_modrm;
    logic is_prefix;
    asd_seg_t seg;
    asd_op_t op;
    logic word;
    logic mem;
    logic [6:0] cycles;
    logic [6:0] cycles_max;
    modport matcher (input opcode, input modrm, output known, output needs_modrm,
        output is_prefix, output seg, output op, output word, output mem, output cycles,
        output cycles_max);
    modport user (output opcode, output modrm, input known, input needs_modrm,
        input is_prefix, input seg, input op, input word, input mem, input cycles,
        input cycles_max);
endinterface : asd_dec_if

// ==== core/asd_match.sv ====
// asd_match.sv: combinational opcode and reg-field matcher with cycle lookup
// assumes: opcode and modrm are held stable by the sequencer while it reads
`timescale 1ns/100ps
`include "asd_consts.svh"
module asd_match (
    asd_dec_if.matcher dec,
    input wire logic narrow_bus
);
    import asd_pkg::*;

    // register or memory pick from the mod field
    function automatic logic [6:0] pick(input logic m, input logic [6:0] r,
                                        input logic [6:0] mm);
        pick = m ? mm : r;
    endfunction : pick

    // one flat decode; first byte then reg field when a second byte is needed
    always_comb begin
        logic [2:0] rf;
        logic m;
        logic w;
        rf = dec.modrm[5:3];
        m = (dec.modrm[7:6] != `ASD_MOD_REG);
        w = dec.opcode[0];
        dec.known = 1'b1;
        dec.needs_modrm = 1'b0;
        dec.is_prefix = 1'b0;
        dec.seg = ASD_SEG_NONE;
        dec.op = ASD_OP_NONE;
        dec.word = w;
        dec.mem = 1'b0;
        dec.cycles = `ASD_CYC_RR;
        dec.cycles_max = `ASD_CYC_RR;
        if (dec.opcode == `ASD_PFX_CS || dec.opcode == `ASD_PFX_SS ||
            dec.opcode == `ASD_PFX_DS || dec.opcode == `ASD_PFX_ES) begin
            dec.is_prefix = 1'b1;
            dec.word = 1'b0;
            dec.cycles = `ASD_CYC_PFX;
            unique case (dec.opcode)
                `ASD_PFX_CS: dec.seg = ASD_SEG_CS;
                `ASD_PFX_SS: dec.seg = ASD_SEG_SS;
                `ASD_PFX_DS: dec.seg = ASD_SEG_DS;
                default: dec.seg = ASD_SEG_ES;
            endcase
        end else if (dec.opcode == `ASD_BCD_ADD) begin
            dec.op = ASD_OP_BCDA;
            dec.word = 1'b0;
            dec.cycles = `ASD_CYC_BCD_ADD;
        end else if (dec.opcode == `ASD_PKD_ADD) begin
            dec.op = ASD_OP_PKDA;
            dec.word = 1'b0;
            dec.cycles = `ASD_CYC_PKD;
        end else if (dec.opcode == `ASD_BCD_SUB) begin
            dec.op = ASD_OP_BCDS;
            dec.word = 1'b0;
            dec.cycles = `ASD_CYC_BCD_SUB;
        end else if (dec.opcode == `ASD_PKD_SUB) begin
            dec.op = ASD_OP_PKDS;
            dec.word = 1'b0;
            dec.cycles = `ASD_CYC_PKD;
        end else if (dec.opcode[7:3] == `ASD_OP_INC_R ||
                     dec.opcode[7:3] == `ASD_OP_DEC_R) begin
            dec.op = dec.opcode[3] ? ASD_OP_DEC : ASD_OP_INC;
            dec.word = 1'b1;
            dec.cycles = `ASD_CYC_RR;
        end else if (dec.opcode[7:1] == `ASD_OP_ADD_AC || dec.opcode[7:1] == `ASD_OP_ADC_AC ||
                     dec.opcode[7:1] == `ASD_OP_SUB_AC || dec.opcode[7:1] == `ASD_OP_SBB_AC ||
                     dec.opcode[7:1] == `ASD_OP_CMP_AC) begin
            unique case (dec.opcode[7:1])
                `ASD_OP_ADD_AC: dec.op = ASD_OP_ADD;
                `ASD_OP_ADC_AC: dec.op = ASD_OP_ADC;
                `ASD_OP_SUB_AC: dec.op = ASD_OP_SUB;
                `ASD_OP_SBB_AC: dec.op = ASD_OP_SBB;
                default: dec.op = ASD_OP_CMP;
            endcase
            dec.cycles = w ? `ASD_CYC_AC16 : `ASD_CYC_AC8;
        end else if (dec.opcode[7:2] == `ASD_OP_ADD_RM || dec.opcode[7:2] == `ASD_OP_ADC_RM ||
                     dec.opcode[7:2] == `ASD_OP_SUB_RM || dec.opcode[7:2] == `ASD_OP_SBB_RM ||
                     dec.opcode[7:2] == `ASD_OP_CMP_RM) begin
            dec.needs_modrm = 1'b1;
            dec.mem = m;
            unique case (dec.opcode[7:2])
                `ASD_OP_ADD_RM: dec.op = ASD_OP_ADD;
                `ASD_OP_ADC_RM: dec.op = ASD_OP_ADC;
                `ASD_OP_SUB_RM: dec.op = ASD_OP_SUB;
                `ASD_OP_SBB_RM: dec.op = ASD_OP_SBB;
                default: dec.op = ASD_OP_CMP;
            endcase
            dec.cycles = pick(m, `ASD_CYC_RR, `ASD_CYC_RM);
        end else if (dec.opcode[7:2] == `ASD_OP_IMM_GRP) begin
            dec.needs_modrm = 1'b1;
            dec.mem = m;
            dec.cycles = pick(m, `ASD_CYC_IR, `ASD_CYC_IM);
            unique case (rf)
                `ASD_REG_ADD: dec.op = ASD_OP_ADD;
                `ASD_REG_ADC: dec.op = ASD_OP_ADC;
                `ASD_REG_SBB: dec.op = ASD_OP_SBB;
                `ASD_REG_SUB: dec.op = ASD_OP_SUB;
                `ASD_REG_CMP: begin
                    dec.op = ASD_OP_CMP;
                    dec.cycles = pick(m, `ASD_CYC_RR, `ASD_CYC_CMPIM);
                end
                default: dec.known = 1'b0; // logic ops live elsewhere
            endcase
        end else if (dec.opcode[7:1] == `ASD_OP_GRP3) begin
            dec.needs_modrm = 1'b1;
            dec.mem = m;
            if (rf == `ASD_REG_NEG) begin
                dec.op = ASD_OP_NEG;
                dec.cycles = pick(m, `ASD_CYC_RR, `ASD_CYC_RM);
            end else if (rf == `ASD_REG_MUL) begin
                dec.op = ASD_OP_MUL;
                dec.cycles = m ? (w ? `ASD_CYC_MUL_MW : `ASD_CYC_MUL_MB)
                               : (w ? `ASD_CYC_MUL_RW : `ASD_CYC_MUL_RB);
            end else begin
                dec.known = 1'b0;
            end
        end else if (dec.opcode[7:1] == `ASD_OP_GRP4) begin
            dec.needs_modrm = 1'b1;
            dec.mem = m;
            if (rf == `ASD_REG_INC || rf == `ASD_REG_DEC) begin
                dec.op = (rf == `ASD_REG_DEC) ? ASD_OP_DEC : ASD_OP_INC;
                dec.cycles = pick(m, `ASD_CYC_RR, `ASD_CYC_INCM);
            end else begin
                dec.known = 1'b0;
            end
        end else begin
            dec.known = 1'b0;
        end
        // narrow bus pays extra for word memory traffic, except the plain adjusts
        if (narrow_bus && dec.needs_modrm && m && w) begin
            dec.cycles = 7'(dec.cycles + `ASD_CYC_NARROW);
        end
        dec.cycles_max = (dec.op == ASD_OP_MUL) ? 7'(dec.cycles + `ASD_CYC_MUL_SPAN)
                                                : dec.cycles;
    end
endmodule : asd_match

// ==== core/asd_decoder.sv ====
// asd_decoder.sv: top of the arithmetic and segment-prefix decoder with cycle timing
// assumes: the fetch queue offers one byte per cycle with valid/ready; no bus interface here
`timescale 1ns/100ps
`include "asd_consts.svh"
// Summary of operation
// - four segment prefixes, two clocks each
// - add with carry three forms, timed
// - subtract with borrow three forms, timed
// - sign change group three, three/ten clocks
// - bcd add correction, eight clocks
// - packed add correction, four clocks
// - bcd sub correction, seven clocks
// - packed sub correction, four clocks
// - unsigned multiply, four latency ranges
// - narrow bus word memory adds four
module asd_decoder (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic narrow_bus,
    input wire logic [7:0] q_byte,
    input wire logic q_valid,
    output logic q_ready,
    output logic issue,
    output asd_pkg::asd_op_t issue_op,
    output asd_pkg::asd_seg_t issue_seg,
    output logic issue_word,
    output logic issue_mem,
    output logic [6:0] issue_cycles,
    output logic [6:0] issue_cycles_max,
    output logic bad_opcode,
    output logic busy
);
    import asd_pkg::*;

    asd_dec_if dec ();
    asd_state_t st_q, st_d;
    logic [7:0] op_q, op_d;
    logic [7:0] mrm_q, mrm_d;
    asd_seg_t seg_q, seg_d;
    logic [6:0] cnt_q, cnt_d;
    logic q_ready_q, q_ready_d;
    logic issue_q, issue_d;
    asd_op_t iop_q, iop_d;
    asd_seg_t iseg_q, iseg_d;
    logic iw_q, iw_d, im_q, im_d, bad_q, bad_d, busy_q, busy_d;
    logic [6:0] icyc_q, icyc_d, imax_q, imax_d;
    logic take;

    asd_match u_match (
        .dec(dec.matcher),
        .narrow_bus(narrow_bus)
    );

    // byte is consumed whenever we advertise ready and the queue offers one
    assign take = q_valid && q_ready_q;
    assign dec.opcode = (st_q == ASD_ST_IDLE) ? q_byte : op_q;
    assign dec.modrm = (st_q == ASD_ST_NEED_MODRM) ? q_byte : mrm_q;

    // sequencing: fetch opcode, maybe modrm, then hold for the cycle count
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        mrm_d = mrm_q;
        seg_d = seg_q;
        cnt_d = cnt_q;
        issue_d = 1'b0;
        iop_d = iop_q;
        iseg_d = iseg_q;
        iw_d = iw_q;
        im_d = im_q;
        icyc_d = icyc_q;
        imax_d = imax_q;
        bad_d = 1'b0;
        unique case (st_q)
            ASD_ST_IDLE: begin
                if (take) begin
                    op_d = q_byte;
                    mrm_d = 8'h00;
                    if (dec.is_prefix) begin
                        seg_d = dec.seg;
                        cnt_d = 7'(`ASD_CYC_PFX - 7'h01);
                        st_d = ASD_ST_BUSY;
                    end else if (!dec.known && !dec.needs_modrm) begin
                        bad_d = 1'b1;
                        seg_d = ASD_SEG_NONE;
                    end else if (dec.needs_modrm) begin
                        st_d = ASD_ST_NEED_MODRM;
                    end else begin
                        issue_d = 1'b1;
                    end
                end
            end
            ASD_ST_NEED_MODRM: begin
                if (take) begin
                    mrm_d = q_byte;
                    if (dec.known) begin
                        issue_d = 1'b1;
                    end else begin
                        bad_d = 1'b1;
                        seg_d = ASD_SEG_NONE;
                        st_d = ASD_ST_IDLE;
                    end
                end
            end
            ASD_ST_BUSY: begin
                if (cnt_q <= 7'h01) begin
                    st_d = ASD_ST_IDLE;
                    cnt_d = 7'h00;
                end else begin
                    cnt_d = 7'(cnt_q - 7'h01);
                end
            end
            default: st_d = ASD_ST_IDLE;
        endcase
        // an issue latches the decode and consumes the pending override
        if (issue_d) begin
            iop_d = dec.op;
            iseg_d = seg_q;
            iw_d = dec.word;
            im_d = dec.mem;
            icyc_d = dec.cycles;
            imax_d = dec.cycles_max;
            seg_d = ASD_SEG_NONE;
            cnt_d = 7'(dec.cycles - 7'h01);
            st_d = (dec.cycles > 7'h01) ? ASD_ST_BUSY : ASD_ST_IDLE;
        end
        // ready is registered from the next state so it falls with busy and no byte is taken while busy
        q_ready_d = (st_d != ASD_ST_BUSY);
        busy_d = (st_d == ASD_ST_BUSY);
    end

    // state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ASD_ST_IDLE;
            op_q <= 8'h00;
            mrm_q <= 8'h00;
            seg_q <= ASD_SEG_NONE;
            cnt_q <= 7'h00;
            q_ready_q <= 1'b0;
            issue_q <= 1'b0;
            iop_q <= ASD_OP_NONE;
            iseg_q <= ASD_SEG_NONE;
            iw_q <= 1'b0;
            im_q <= 1'b0;
            icyc_q <= 7'h00;
            imax_q <= 7'h00;
            bad_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            mrm_q <= mrm_d;
            seg_q <= seg_d;
            cnt_q <= cnt_d;
            q_ready_q <= q_ready_d;
            issue_q <= issue_d;
            iop_q <= iop_d;
            iseg_q <= iseg_d;
            iw_q <= iw_d;
            im_q <= im_d;
            icyc_q <= icyc_d;
            imax_q <= imax_d;
            bad_q <= bad_d;
            busy_q <= busy_d;
        end
    end

    assign q_ready = q_ready_q;
    assign issue = issue_q;
    assign issue_op = iop_q;
    assign issue_seg = iseg_q;
    assign issue_word = iw_q;
    assign issue_mem = im_q;
    assign issue_cycles = icyc_q;
    assign issue_cycles_max = imax_q;
    assign bad_opcode = bad_q;
    assign busy = busy_q;

    // checks on timing figures carried with each issue, on busy run lengths and on ready while busy
    chk_bcd_add_time: assert property (@(posedge clk) disable iff (!rst_n)
        issue && issue_op == ASD_OP_BCDA |-> issue_cycles == 7'h08)
        else $error("bcd add correction not eight cycles");
    chk_packed_time: assert property (@(posedge clk) disable iff (!rst_n)
        issue && (issue_op == ASD_OP_PKDA || issue_op == ASD_OP_PKDS) |-> issue_cycles == 7'h04)
        else $error("packed correction not four cycles");
    chk_bcd_sub_time: assert property (@(posedge clk) disable iff (!rst_n)
        issue && issue_op == ASD_OP_BCDS |-> issue_cycles == 7'h07)
        else $error("bcd sub correction not seven cycles");
    chk_mul_span: assert property (@(posedge clk) disable iff (!rst_n)
        issue && issue_op == ASD_OP_MUL |-> issue_cycles_max == 7'(issue_cycles + 7'h02)
        && issue_cycles >= 7'h1a)
        else $error("multiply latency span wrong");
    chk_prefix_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(busy) && !$past(issue_d) && !issue |-> busy [*1] ##1 !busy)
        else $error("prefix did not take two cycles");
    chk_busy_length: assert property (@(posedge clk) disable iff (!rst_n)
        issue && issue_op == ASD_OP_ADC && !issue_mem && issue_cycles == 7'h03
        |-> busy [*2] ##1 !busy)
        else $error("register add with carry not three cycles");
    chk_sbb_mem: assert property (@(posedge clk) disable iff (!rst_n)
        issue && issue_op == ASD_OP_SBB && issue_mem && !narrow_bus
        |-> issue_cycles == 7'h0a || issue_cycles == 7'h10)
        else $error("memory subtract with borrow cycle count wrong");
    chk_neg_time: assert property (@(posedge clk) disable iff (!rst_n)
        issue && issue_op == ASD_OP_NEG && !issue_mem |-> issue_cycles == 7'h03)
        else $error("register sign change not three cycles");
    chk_no_take_busy: assert property (@(posedge clk) disable iff (!rst_n)
        busy |-> !q_ready)
        else $error("byte accepted while busy");
    chk_narrow_word: assert property (@(posedge clk) disable iff (!rst_n)
        issue && issue_op == ASD_OP_ADD && issue_mem && issue_word && narrow_bus
        && $stable(narrow_bus) |-> issue_cycles == 7'h0e || issue_cycles == 7'h14)
        else $error("narrow bus word memory add not extended");
    chk_cmp_imm_reg: assert property (@(posedge clk) disable iff (!rst_n)
        issue && issue_op == ASD_OP_CMP && !issue_mem |-> issue_cycles <= 7'h04)
        else $error("register compare over four cycles");
    chk_incdec_time: assert property (@(posedge clk) disable iff (!rst_n)
        issue && (issue_op == ASD_OP_INC || issue_op == ASD_OP_DEC) && !issue_mem
        |-> issue_cycles == 7'h03)
        else $error("register increment or decrement not three cycles");
endmodule : asd_decoder

// ==== sim/tb.sv ====
// tb.sv: self-checking bench for the arithmetic and segment-prefix decoder
// assumes: asd_pkg and the core files are compiled first; one clock, async active-low reset
`timescale 1ns/100ps
module tb;
    import asd_pkg::*;
    typedef struct packed {
        logic needm;
        asd_op_t op;
        logic word;
        logic mem;
        logic [6:0] cyc;
        logic [6:0] cmax;
    } asd_exp_t;
    logic clk;
    logic rst_n;
    logic narrow_bus;
    logic [7:0] q_byte;
    logic q_valid;
    logic q_ready;
    logic issue;
    asd_op_t issue_op;
    asd_seg_t issue_seg;
    logic issue_word;
    logic issue_mem;
    logic [6:0] issue_cycles;
    logic [6:0] issue_cycles_max;
    logic bad_opcode;
    logic busy;
    int fail_count = 0;
    int tests_run = 0;
    int cyc_count = 0;
    int i;
    int k;
    logic [7:0] b;
    logic [7:0] pfx [4] = '{8'h2e, 8'h36, 8'h3e, 8'h26};
    logic [7:0] adj [4] = '{8'h37, 8'h27, 8'h3f, 8'h2f};
    logic [7:0] base [15] = '{8'h00, 8'h10, 8'h28, 8'h18, 8'h38, 8'h04, 8'h14, 8'h2c,
        8'h1c, 8'h3c, 8'h80, 8'hf6, 8'hfe, 8'h40, 8'h48};
    logic [7:0] msk [15] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h01, 8'h01, 8'h01,
        8'h01, 8'h01, 8'h03, 8'h01, 8'h01, 8'h07, 8'h07};

    asd_decoder dut (.clk(clk), .rst_n(rst_n), .narrow_bus(narrow_bus), .q_byte(q_byte),
        .q_valid(q_valid), .q_ready(q_ready), .issue(issue), .issue_op(issue_op),
        .issue_seg(issue_seg), .issue_word(issue_word), .issue_mem(issue_mem),
        .issue_cycles(issue_cycles), .issue_cycles_max(issue_cycles_max),
        .bad_opcode(bad_opcode), .busy(busy));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard: the whole run needs well under a tenth of this
    always @(posedge clk) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 60000) begin
            fail_count = fail_count + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // reg-field and opcode-bit selector shared by all alu encodings
    function automatic asd_op_t alu(input logic [2:0] r);
        case (r)
            3'h0: return ASD_OP_ADD;
            3'h2: return ASD_OP_ADC;
            3'h3: return ASD_OP_SBB;
            3'h5: return ASD_OP_SUB;
            3'h7: return ASD_OP_CMP;
            default: return ASD_OP_NONE;
        endcase
    endfunction : alu

    function automatic asd_seg_t seg_of(input logic [7:0] p);
        case (p)
            8'h2e: return ASD_SEG_CS;
            8'h36: return ASD_SEG_SS;
            8'h3e: return ASD_SEG_DS;
            8'h26: return ASD_SEG_ES;
            default: return ASD_SEG_NONE;
        endcase
    endfunction : seg_of

    // reference decode; op NONE means the decoder must reject
    function automatic asd_exp_t model(input logic [7:0] op, input logic [7:0] m,
            input logic nb);
        asd_exp_t e;
        logic mm;
        mm = (m[7:6] != 2'h3);
        e = '0;
        e.word = op[0];
        e.cyc = op[0] ? 7'h04 : 7'h03; // accumulator forms, 8/16-bit
        casez (op)
            8'b000000??, 8'b000100??, 8'b001010??, 8'b000110??, 8'b001110??: begin
                e.op = alu(op[5:3]);
                e.needm = 1'b1;
                e.cyc = mm ? 7'h0a : 7'h03;
            end
            8'b0000010?, 8'b0001010?, 8'b0010110?, 8'b0001110?, 8'b0011110?:
                e.op = alu(op[5:3]);
            8'b100000??: begin
                e.op = alu(m[5:3]);
                e.needm = 1'b1;
                e.cyc = (m[5:3] == 3'h7) ? (mm ? 7'h0a : 7'h03) : (mm ? 7'h10 : 7'h04);
            end
            8'b1111011?: begin
                e.needm = 1'b1;
                e.op = (m[5:3] == 3'h3) ? ASD_OP_NEG : (m[5:3] == 3'h4) ? ASD_OP_MUL
                    : ASD_OP_NONE;
                e.cyc = mm ? 7'h0a : 7'h03;
                if (m[5:3] == 3'h4)
                    e.cyc = op[0] ? (mm ? 7'h29 : 7'h23) : (mm ? 7'h20 : 7'h1a);
            end
            8'b1111111?: begin
                e.needm = 1'b1;
                e.op = (m[5:3] == 3'h0) ? ASD_OP_INC : (m[5:3] == 3'h1) ? ASD_OP_DEC
                    : ASD_OP_NONE;
                e.cyc = mm ? 7'h0f : 7'h03;
            end
            8'b0100????: begin
                e.op = op[3] ? ASD_OP_DEC : ASD_OP_INC;
                e.word = 1'b1;
                e.cyc = 7'h03;
            end
            8'h37, 8'h27, 8'h3f, 8'h2f: begin
                e.word = 1'b0; // adjusts work on the low byte only
                e.cyc = (op == 8'h37) ? 7'h08 : (op == 8'h3f) ? 7'h07 : 7'h04;
                e.op = (op == 8'h37) ? ASD_OP_BCDA : (op == 8'h27) ? ASD_OP_PKDA
                    : (op == 8'h3f) ? ASD_OP_BCDS : ASD_OP_PKDS;
            end
            default: e.op = ASD_OP_NONE;
        endcase
        e.mem = e.needm & mm;
        if (e.needm && nb && e.word && e.mem)
            e.cyc = e.cyc + 7'h04;
        e.cmax = e.cyc + ((e.op == ASD_OP_MUL) ? 7'h02 : 7'h00);
        return e;
    endfunction : model

    // offer a byte from an edge and hold it until the edge that takes it
    task automatic send(input logic [7:0] v, output int waits);
        q_byte <= v;
        q_valid <= 1'b1;
        waits = 0;
        do begin
            @(posedge clk);
            waits = waits + 1;
        end while (q_ready !== 1'b1 && waits < 200);
    endtask : send

    // one instruction, optional prefix p (zero means none), then all result checks
    task automatic do_insn(input logic [7:0] p, input logic [7:0] op, input logic [7:0] m,
            input logic nb);
        asd_exp_t e;
        int w;
        int n;
        e = model(op, m, nb);
        @(posedge clk);
        narrow_bus <= nb;
        if (p != 8'h00) begin
            send(p, w);
            send(op, w);
            chk(w, 2);
        end else begin
            send(op, w);
        end
        if (e.needm)
            send(m, w);
        q_valid <= 1'b0;
        n = 0;
        #1;
        while (issue !== 1'b1 && bad_opcode !== 1'b1 && n < 6) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        if (e.op == ASD_OP_NONE) begin
            chk({bad_opcode, issue}, 2'h2);
            // the reject pulse lasts one cycle and the queue is open again
            @(posedge clk);
            #1;
            chk({bad_opcode, q_ready}, 2'h1);
        end else begin
            chk({issue, bad_opcode}, 2'h2);
            chk(issue_op, e.op);
            chk(issue_seg, seg_of(p));
            chk({issue_word, issue_mem}, {e.word, e.mem});
            chk(issue_cycles, e.cyc);
            chk(issue_cycles_max, e.cmax);
            n = 0;
            // the decoder must refuse bytes for the whole run of the instruction
            while (busy === 1'b1 && n < 100) begin
                chk({(n > 0) ? issue : 1'b0, q_ready}, 2'h0);
                @(posedge clk);
                #1;
                n = n + 1;
            end
            chk(n, e.cyc - 1);
        end
        $display("test done: opcode %h modrm %h at %0t ns", op, m, $time);
    endtask : do_insn

    initial begin
        rst_n = 1'b0;
        narrow_bus = 1'b0;
        q_byte = 8'h00;
        q_valid = 1'b0;
        void'($urandom(29));
        repeat (4) @(posedge clk);
        #1;
        chk({q_ready, issue, bad_opcode, busy}, 4'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i++)
            do_insn(pfx[i], 8'h10, 8'hc0, 1'b0);
        do_insn(8'h00, 8'h12, 8'h06, 1'b0);
        do_insn(8'h00, 8'h81, 8'h16, 1'b1);
        do_insn(8'h00, 8'h15, 8'h00, 1'b0);
        do_insn(8'h00, 8'h1b, 8'hc8, 1'b1);
        do_insn(8'h00, 8'h83, 8'h18, 1'b0);
        do_insn(8'h00, 8'h1c, 8'h00, 1'b0);
        do_insn(8'h00, 8'hf7, 8'hd8, 1'b0);
        do_insn(8'h00, 8'hf6, 8'h1e, 1'b1);
        for (i = 0; i < 4; i++)
            do_insn(8'h00, adj[i], 8'h00, i[0]);
        for (i = 0; i < 6; i++)
            do_insn(8'h00, i[0] ? 8'hf7 : 8'hf6, (i < 2) ? 8'he0 : 8'h20, i > 3);
        do_insn(8'h00, 8'h80, 8'h06, 1'b0);
        do_insn(8'h00, 8'h80, 8'hee, 1'b0);
        do_insn(8'h00, 8'h83, 8'h3e, 1'b1);
        do_insn(8'h00, 8'h3a, 8'hc0, 1'b0);
        do_insn(8'h00, 8'h3d, 8'h00, 1'b0);
        do_insn(8'h00, 8'h29, 8'h07, 1'b1);
        do_insn(8'h00, 8'h2d, 8'h00, 1'b0);
        do_insn(8'h00, 8'hfe, 8'hc0, 1'b0);
        do_insn(8'h00, 8'hff, 8'h0e, 1'b1);
        do_insn(8'h00, 8'h43, 8'h00, 1'b0);
        do_insn(8'h00, 8'h4f, 8'h00, 1'b0);
        do_insn(8'h00, 8'h80, 8'hc8, 1'b0);
        do_insn(8'h00, 8'hf6, 8'hc0, 1'b0);
        do_insn(8'h00, 8'hfe, 8'hd0, 1'b0);
        do_insn(8'h2e, 8'h90, 8'h00, 1'b0);
        do_insn(8'h00, 8'h10, 8'hc0, 1'b0);
        $display("test done: directed corner cases");
        // random mix, biased towards the decoded groups
        for (i = 0; i < 240; i++) begin
            k = $urandom_range(15, 0);
            b = (k == 15) ? 8'($urandom) : (base[k] | (8'($urandom) & msk[k]));
            if (seg_of(b) != ASD_SEG_NONE)
                b = 8'h37;
            do_insn(($urandom_range(3, 0) == 0) ? pfx[$urandom_range(3, 0)] : 8'h00, b,
                8'($urandom), 1'($urandom));
        end
        $display("test done: random instruction mix");
        end_of_test();
    end
endmodule : tb
